// ==== core/engine_regs_pkg.sv ====
// Register numbers, field layouts and carriers of the holding registers.
package engine_regs_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register numbers as carried in the request address.
    localparam logic [15:0] ADDR_ACTUAL_LEVEL = 16'h9c4b;
    localparam logic [15:0] ADDR_REMOTE_RUN = 16'h9c4c;
    localparam logic [15:0] ADDR_MAX_SPEED = 16'h9c4d;
    localparam logic [15:0] ADDR_AMBIENT = 16'h9c4e;
    localparam logic [15:0] ADDR_MODE_SELECT = 16'h9c4f;
    localparam logic [15:0] ADDR_LOADED_SPEED = 16'h9c50;
    localparam logic [15:0] ADDR_MANUAL_LOCK = 16'h9c51;
    localparam logic [15:0] ADDR_PRESTART1 = 16'h9c52;
    localparam logic [15:0] ADDR_PRESTART2 = 16'h9c53;
    localparam logic [15:0] ADDR_TORQUE = 16'h9c54;
    localparam logic [15:0] ADDR_RESERVED_A = 16'h9c55;
    localparam logic [15:0] ADDR_FILTER_OUT_T = 16'h9c56;
    localparam logic [15:0] ADDR_FILTER_IN_T = 16'h9c57;
    localparam logic [15:0] ADDR_EXHAUST_T = 16'h9c58;
    localparam logic [15:0] ADDR_MANIFOLD_T = 16'h9c59;
    localparam logic [15:0] ADDR_BOOST = 16'h9c5a;
    localparam logic [15:0] ADDR_FUEL_T = 16'h9c5b;
    localparam logic [15:0] ADDR_INTERCOOLER_T = 16'h9c5c;
    localparam logic [15:0] ADDR_ASH_LOAD = 16'h9c5d;
    localparam logic [15:0] ADDR_FLUID_TANK_T = 16'h9c5e;
    localparam logic [15:0] ADDR_FUEL_PRESS = 16'h9c5f;
    localparam logic [15:0] ADDR_BARO = 16'h9c60;
    localparam logic [15:0] ADDR_AIR_DIFF = 16'h9c61;
    localparam logic [15:0] ADDR_EXH_GAS_T = 16'h9c62;
    localparam logic [15:0] ADDR_HYD_PRESS = 16'h9c63;
    localparam logic [15:0] ADDR_HYD_T = 16'h9c64;
    localparam logic [15:0] ADDR_REGEN_STATE = 16'h9c65;
    localparam logic [15:0] ADDR_LEVEL_START = 16'h9c66;
    localparam logic [15:0] ADDR_LEVEL_STOP = 16'h9c67;
    localparam logic [15:0] ADDR_LEVEL_MAINTAIN = 16'h9c68;
    localparam logic [15:0] ADDR_FLOW_START = 16'h9c69;
    localparam logic [15:0] ADDR_FLOW_STOP = 16'h9c6a;
    localparam logic [15:0] ADDR_DISCHARGE_HI = 16'h9c6b;
    localparam logic [15:0] ADDR_DISCHARGE_LO = 16'h9c6c;
    localparam logic [15:0] ADDR_PSTART_HI = 16'h9c6d;
    localparam logic [15:0] ADDR_PSTART_LO = 16'h9c6e;
    localparam logic [15:0] ADDR_PSTOP_HI = 16'h9c6f;
    localparam logic [15:0] ADDR_PSTOP_LO = 16'h9c70;
    localparam logic [15:0] ADDR_PMAINT_HI = 16'h9c71;
    localparam logic [15:0] ADDR_PMAINT_LO = 16'h9c72;
    localparam logic [15:0] ADDR_RSVD_FIRST = 16'h9c73;
    localparam logic [15:0] ADDR_RSVD_LAST = 16'h9d08;
    localparam logic [15:0] ADDR_APP_VER1 = 16'h9d09;
    localparam logic [15:0] ADDR_APP_VER2 = 16'h9d0a;
    localparam logic [15:0] ADDR_APP_VER4 = 16'h9d0c;
    localparam logic [15:0] ADDR_CFG_VER1 = 16'h9d0d;
    localparam logic [15:0] ADDR_CFG_VER2 = 16'h9d0e;
    localparam logic [15:0] ADDR_CFG_VER3 = 16'h9d0f;
    localparam logic [15:0] ADDR_RESERVED_B = 16'h9d10;
    localparam logic [15:0] ADDR_CATALYST_LEVEL = 16'h9d12;
    localparam logic [15:0] ADDR_SOOT_LOAD = 16'h9d13;
    localparam logic [15:0] ADDR_INHIBIT_SWITCH = 16'h9d14;
    localparam logic [15:0] ADDR_INHIBIT_FLAGS = 16'h9d15;

    ////////////////////////////////////////////////////////////////////////
    // Field positions and reset values.
    localparam int FLAG_BIT = 0;
    localparam int INHIBIT_SWITCH_BIT = 0;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [31:0] PAIR_ZERO = 32'h0000_0000;
    localparam logic FLAG_RESET = 1'b0;

    // Particulate-filter regeneration status codes.
    typedef enum logic [1:0] {
        REGEN_NOT_ACTIVE = 2'b00,
        REGEN_ACTIVE = 2'b01,
        REGEN_NEEDED = 2'b10,
        REGEN_NOT_AVAILABLE = 2'b11
    } regen_state_t;

    // Live telemetry mirrored from the engine data link.
    typedef struct packed {
        logic [15:0] level;
        logic [15:0] ambient;
        logic [15:0] torque;
        logic [15:0] filter_out_t;
        logic [15:0] filter_in_t;
        logic [15:0] exhaust_t;
        logic [15:0] manifold_t;
        logic [15:0] boost;
        logic [15:0] fuel_t;
        logic [15:0] intercooler_t;
        logic [15:0] ash_load;
        logic [15:0] fluid_tank_t;
        logic [15:0] fuel_press;
        logic [15:0] baro;
        logic [15:0] air_diff;
        logic [15:0] exh_gas_t;
        logic [15:0] hyd_press;
        logic [15:0] hyd_t;
        regen_state_t regen;
        logic [31:0] discharge;
        logic [15:0] catalyst_level;
        logic [15:0] soot_load;
        logic inhibit_switch;
        logic inhibit_active;
    } telemetry_t;

    // Setpoints held for the controller.
    typedef struct packed {
        logic [15:0] max_speed;
        logic [15:0] loaded_speed;
        logic [15:0] level_start;
        logic [15:0] level_stop;
        logic [15:0] level_maintain;
        logic [15:0] flow_start;
        logic [15:0] flow_stop;
        logic [31:0] press_start;
        logic [31:0] press_stop;
        logic [31:0] press_maintain;
    } setpoints_t;

    // Effective operating controls after mode qualification.
    typedef struct packed {
        logic auto_mode;
        logic manual_lock;
        logic run_start;
        logic prestart1_en;
        logic prestart2_en;
    } mode_ctrl_t;

endpackage

// ==== core/engine_ctrl_holding_regs.sv ====
// Holding-register bank: telemetry readback, setpoints and mode controls.
module engine_ctrl_holding_regs
#(
    parameter logic [15:0] APP_VER1 = 16'h0001, // Arbitrary value.
    parameter logic [15:0] APP_VER2 = 16'h0002, // Arbitrary value.
    parameter logic [15:0] APP_VER4 = 16'h0004, // Arbitrary value.
    parameter logic [15:0] CFG_VER1 = 16'h0001, // Arbitrary value.
    parameter logic [15:0] CFG_VER2 = 16'h0002, // Arbitrary value.
    parameter logic [15:0] CFG_VER3 = 16'h0003 // Arbitrary value.
)
(
    input wire logic sys_clk, // System clock, 50 MHz.
    input wire logic rst_b, // Asynchronous reset, active low.
    input wire logic req_valid, // Register request strobe.
    input wire logic req_write, // One for write, zero for read.
    input wire logic [15:0] req_addr, // Holding register number.
    input wire logic [15:0] req_wdata, // Write data.
    input wire engine_regs_pkg::telemetry_t telem, // Live telemetry.
    output logic resp_valid, // Answer strobe, one cycle.
    output logic [15:0] resp_rdata, // Read data.
    output logic resp_err, // Unmapped register number.
    output engine_regs_pkg::setpoints_t setp, // Held setpoints.
    output engine_regs_pkg::mode_ctrl_t mode_ctrl // Effective controls.
);
    import engine_regs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Request decode.
    logic wr_en;
    logic rd_en;
    logic hit;
    logic [15:0] rd_word;
    setpoints_t setp_q;
    mode_ctrl_t mode_q;
    logic run_cmd_q;
    logic mode_sel_q;
    logic lock_q;
    logic pre1_q;
    logic pre2_q;
    logic auto_eff;

    assign wr_en = req_valid & req_write;
    assign rd_en = req_valid & ~req_write;

    ////////////////////////////////////////////////////////////////////////
    // Single-bit controls keep only bit zero; the rest of the word is
    // dropped so a stray high bit cannot flip a mode.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            run_cmd_q <= FLAG_RESET;
            mode_sel_q <= FLAG_RESET;
            lock_q <= FLAG_RESET;
            pre1_q <= FLAG_RESET;
            pre2_q <= FLAG_RESET;
        end
        else if (wr_en)
        begin
            case (req_addr)
                ADDR_REMOTE_RUN: run_cmd_q <= req_wdata[FLAG_BIT];
                ADDR_MODE_SELECT: mode_sel_q <= req_wdata[FLAG_BIT];
                ADDR_MANUAL_LOCK: lock_q <= req_wdata[FLAG_BIT];
                ADDR_PRESTART1: pre1_q <= req_wdata[FLAG_BIT];
                ADDR_PRESTART2: pre2_q <= req_wdata[FLAG_BIT];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Setpoint words. Pairs put the lower register number in the upper
    // half, so a master writing in address order fills high then low.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            setp_q.max_speed <= WORD_ZERO;
            setp_q.loaded_speed <= WORD_ZERO;
            setp_q.level_start <= WORD_ZERO;
            setp_q.level_stop <= WORD_ZERO;
            setp_q.level_maintain <= WORD_ZERO;
            setp_q.flow_start <= WORD_ZERO;
            setp_q.flow_stop <= WORD_ZERO;
            setp_q.press_start <= PAIR_ZERO;
            setp_q.press_stop <= PAIR_ZERO;
            setp_q.press_maintain <= PAIR_ZERO;
        end
        else if (wr_en)
        begin
            // Read-only and reserved numbers fall to default untouched.
            case (req_addr)
                ADDR_MAX_SPEED: setp_q.max_speed <= req_wdata;
                ADDR_LOADED_SPEED: setp_q.loaded_speed <= req_wdata;
                ADDR_LEVEL_START: setp_q.level_start <= req_wdata;
                ADDR_LEVEL_STOP: setp_q.level_stop <= req_wdata;
                ADDR_LEVEL_MAINTAIN:
                    setp_q.level_maintain <= req_wdata;
                ADDR_FLOW_START: setp_q.flow_start <= req_wdata;
                ADDR_FLOW_STOP: setp_q.flow_stop <= req_wdata;
                ADDR_PSTART_HI:
                    setp_q.press_start[31:16] <= req_wdata;
                ADDR_PSTART_LO: setp_q.press_start[15:0] <= req_wdata;
                ADDR_PSTOP_HI: setp_q.press_stop[31:16] <= req_wdata;
                ADDR_PSTOP_LO: setp_q.press_stop[15:0] <= req_wdata;
                ADDR_PMAINT_HI:
                    setp_q.press_maintain[31:16] <= req_wdata;
                ADDR_PMAINT_LO:
                    setp_q.press_maintain[15:0] <= req_wdata;
                default: ;
            endcase
        end
    end

    assign setp = setp_q;

    ////////////////////////////////////////////////////////////////////////
    // Effective mode. The lock wins over the mode word but does not alter
    // it, so clearing the lock restores what software last selected.
    assign auto_eff = mode_sel_q & ~lock_q;

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mode_q <= '0;
        end
        else
        begin
            mode_q.auto_mode <= auto_eff;
            mode_q.manual_lock <= lock_q;
            mode_q.run_start <= auto_eff & run_cmd_q;
            mode_q.prestart1_en <= auto_eff | ~pre1_q;
            mode_q.prestart2_en <= auto_eff | ~pre2_q;
        end
    end

    assign mode_ctrl = mode_q;

    ////////////////////////////////////////////////////////////////////////
    // Read multiplexer. Telemetry is taken live at the request edge.
    always_comb
    begin
        hit = 1'b1;
        rd_word = WORD_ZERO;
        case (req_addr)
            ADDR_ACTUAL_LEVEL: rd_word = telem.level;
            ADDR_REMOTE_RUN: rd_word = {15'h0000, run_cmd_q};
            ADDR_MAX_SPEED: rd_word = setp_q.max_speed;
            ADDR_AMBIENT: rd_word = telem.ambient;
            ADDR_MODE_SELECT: rd_word = {15'h0000, mode_sel_q};
            ADDR_LOADED_SPEED: rd_word = setp_q.loaded_speed;
            ADDR_MANUAL_LOCK: rd_word = {15'h0000, lock_q};
            ADDR_PRESTART1: rd_word = {15'h0000, pre1_q};
            ADDR_PRESTART2: rd_word = {15'h0000, pre2_q};
            ADDR_TORQUE: rd_word = telem.torque;
            ADDR_RESERVED_A: rd_word = WORD_ZERO;
            ADDR_FILTER_OUT_T: rd_word = telem.filter_out_t;
            ADDR_FILTER_IN_T: rd_word = telem.filter_in_t;
            ADDR_EXHAUST_T: rd_word = telem.exhaust_t;
            ADDR_MANIFOLD_T: rd_word = telem.manifold_t;
            ADDR_BOOST: rd_word = telem.boost;
            ADDR_FUEL_T: rd_word = telem.fuel_t;
            ADDR_INTERCOOLER_T: rd_word = telem.intercooler_t;
            ADDR_ASH_LOAD: rd_word = telem.ash_load;
            ADDR_FLUID_TANK_T: rd_word = telem.fluid_tank_t;
            ADDR_FUEL_PRESS: rd_word = telem.fuel_press;
            ADDR_BARO: rd_word = telem.baro;
            ADDR_AIR_DIFF: rd_word = telem.air_diff;
            ADDR_EXH_GAS_T: rd_word = telem.exh_gas_t;
            ADDR_HYD_PRESS: rd_word = telem.hyd_press;
            ADDR_HYD_T: rd_word = telem.hyd_t;
            ADDR_REGEN_STATE: rd_word = {14'h0000, telem.regen};
            ADDR_LEVEL_START: rd_word = setp_q.level_start;
            ADDR_LEVEL_STOP: rd_word = setp_q.level_stop;
            ADDR_LEVEL_MAINTAIN: rd_word = setp_q.level_maintain;
            ADDR_FLOW_START: rd_word = setp_q.flow_start;
            ADDR_FLOW_STOP: rd_word = setp_q.flow_stop;
            ADDR_DISCHARGE_HI: rd_word = telem.discharge[31:16];
            ADDR_DISCHARGE_LO: rd_word = telem.discharge[15:0];
            ADDR_PSTART_HI: rd_word = setp_q.press_start[31:16];
            ADDR_PSTART_LO: rd_word = setp_q.press_start[15:0];
            ADDR_PSTOP_HI: rd_word = setp_q.press_stop[31:16];
            ADDR_PSTOP_LO: rd_word = setp_q.press_stop[15:0];
            ADDR_PMAINT_HI: rd_word = setp_q.press_maintain[31:16];
            ADDR_PMAINT_LO: rd_word = setp_q.press_maintain[15:0];
            ADDR_APP_VER1: rd_word = APP_VER1;
            ADDR_APP_VER2: rd_word = APP_VER2;
            ADDR_APP_VER4: rd_word = APP_VER4;
            ADDR_CFG_VER1: rd_word = CFG_VER1;
            ADDR_CFG_VER2: rd_word = CFG_VER2;
            ADDR_CFG_VER3: rd_word = CFG_VER3;
            ADDR_RESERVED_B: rd_word = WORD_ZERO;
            ADDR_CATALYST_LEVEL: rd_word = telem.catalyst_level;
            ADDR_SOOT_LOAD: rd_word = telem.soot_load;
            ADDR_INHIBIT_SWITCH:
                rd_word = {15'h0000, telem.inhibit_switch};
            ADDR_INHIBIT_FLAGS:
                rd_word = {15'h0000, telem.inhibit_active};
            default:
            begin
                // The long reserved span answers zero; anything else is
                // refused so a mistyped number is not silently accepted.
                hit = (req_addr >= ADDR_RSVD_FIRST) &&
                      (req_addr <= ADDR_RSVD_LAST);
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Answer register: one cycle after each request, reads and writes.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            resp_valid <= 1'b0;
            resp_rdata <= WORD_ZERO;
            resp_err <= 1'b0;
        end
        else
        begin
            resp_valid <= req_valid;
            resp_err <= req_valid & ~hit;
            resp_rdata <= (rd_en && hit) ? rd_word : WORD_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks on the bank's own outputs.
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_write(logic [15:0] a);
        req_valid && req_write && req_addr == a;
    endsequence

    sequence s_read(logic [15:0] a);
        req_valid && !req_write && req_addr == a;
    endsequence

    a_level_readback: assert property (
        s_read(ADDR_ACTUAL_LEVEL) |=> resp_valid &&
            resp_rdata == $past(telem.level))
        else $error("level readback wrong");

    a_run_auto_only: assert property (
        mode_ctrl.run_start |-> mode_ctrl.auto_mode)
        else $error("run start outside auto mode");

    a_mode_select: assert property (
        (s_write(ADDR_MODE_SELECT) ##0 !lock_q ##1 !wr_en)
            |=> mode_ctrl.auto_mode == $past(req_wdata[FLAG_BIT], 2))
        else $error("mode select not applied");

    a_lock_manual: assert property (
        lock_q |=> !mode_ctrl.auto_mode && mode_ctrl.manual_lock)
        else $error("manual lock ignored");

    a_prestart1_both: assert property (
        !pre1_q |=> mode_ctrl.prestart1_en)
        else $error("prestart one not enabled in both modes");

    a_prestart2_auto: assert property (
        pre2_q && !auto_eff |=> !mode_ctrl.prestart2_en)
        else $error("prestart two enabled outside auto");

    a_max_speed_store: assert property (
        s_write(ADDR_MAX_SPEED) |=> setp.max_speed == $past(req_wdata))
        else $error("speed limit not stored");

    a_regen_code: assert property (
        s_read(ADDR_REGEN_STATE) |=> resp_rdata[15:2] == 14'h0000 &&
            resp_rdata[1:0] == $past(telem.regen))
        else $error("regeneration code wrong");

    a_inhibit_flags: assert property (
        s_read(ADDR_INHIBIT_FLAGS) |=> resp_rdata ==
            {15'h0000, $past(telem.inhibit_active)})
        else $error("inhibit flags wrong");

    a_ro_write_kept: assert property (
        s_write(ADDR_ACTUAL_LEVEL) |=> $stable(setp) && !resp_err)
        else $error("read-only write disturbed state");

    a_pair_upper: assert property (
        s_write(ADDR_PSTART_HI) |=> setp.press_start[31:16] ==
            $past(req_wdata) && $stable(setp.press_start[15:0]))
        else $error("pressure pair order wrong");

    a_unmapped_err: assert property (
        req_valid && !hit |=> resp_valid && resp_err && resp_rdata == 16'h0000)
        else $error("unmapped number not refused");

    // Every request gets exactly one answer, one cycle later.
    a_answer_once: assert property (
        req_valid |=> resp_valid)
        else $error("request not answered");

    a_no_spurious: assert property (
        !req_valid |=> !resp_valid && !resp_err)
        else $error("answer without request");

    // Writes carry no data back, so an echo is never mistaken for data.
    a_write_no_data: assert property (
        req_valid && req_write |=> resp_rdata == 16'h0000)
        else $error("write answered with data");

    a_reserved_zero: assert property (
        req_valid && req_addr >= ADDR_RSVD_FIRST &&
            req_addr <= ADDR_RSVD_LAST |=> resp_rdata == 16'h0000 &&
            !resp_err)
        else $error("reserved span not zero");

    // Run takes effect only while automatic operation is effective.
    a_run_follows: assert property (
        run_cmd_q && mode_sel_q && !lock_q |=> mode_ctrl.run_start)
        else $error("run command ignored in auto mode");

    a_manual_no_run: assert property (
        !mode_sel_q |=> !mode_ctrl.run_start && !mode_ctrl.auto_mode)
        else $error("run start in manual mode");

    a_loaded_store: assert property (
        s_write(ADDR_LOADED_SPEED) |=> setp.loaded_speed == $past(req_wdata))
        else $error("loaded speed not stored");

    a_inhibit_switch: assert property (
        s_read(ADDR_INHIBIT_SWITCH) |=> resp_rdata ==
            {15'h0000, $past(telem.inhibit_switch)})
        else $error("inhibit switch wrong");

    a_level_start: assert property (
        s_write(ADDR_LEVEL_START) |=> setp.level_start == $past(req_wdata))
        else $error("level start not stored");

    a_level_stop: assert property (
        s_write(ADDR_LEVEL_STOP) |=> setp.level_stop == $past(req_wdata))
        else $error("level stop not stored");

    a_level_maintain: assert property (
        s_write(ADDR_LEVEL_MAINTAIN) |=>
            setp.level_maintain == $past(req_wdata))
        else $error("level target not stored");

    // Halves land independently; the other half must not move.
    a_pair_lower: assert property (
        s_write(ADDR_PSTART_LO) |=> setp.press_start[15:0] ==
            $past(req_wdata) && $stable(setp.press_start[31:16]))
        else $error("pressure low half wrong");

    a_maintain_pair: assert property (
        s_write(ADDR_PMAINT_HI) |=> setp.press_maintain[31:16] ==
            $past(req_wdata) && $stable(setp.press_maintain[15:0]))
        else $error("maintain high half wrong");

    a_discharge_hi: assert property (
        s_read(ADDR_DISCHARGE_HI) |=> resp_rdata ==
            $past(telem.discharge[31:16]))
        else $error("discharge high half wrong");

endmodule

// ==== bench/reg_master_model.sv ====
// Register-port master model issuing one request at a time.
module reg_master_model
(
    input wire logic sys_clk, // System clock.
    output logic req_valid, // Request strobe.
    output logic req_write, // Write select.
    output logic [15:0] req_addr, // Register number.
    output logic [15:0] req_wdata, // Write data.
    input wire logic resp_valid, // Answer strobe.
    input wire logic [15:0] resp_rdata, // Read data.
    input wire logic resp_err // Unmapped flag.
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle at time zero so reset sees no request.
    initial
    begin
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 16'h0000;
        req_wdata = 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////
    // One transfer: drive off the edge, taken at the next rising edge,
    // answer sampled mid-cycle where it stands. Released lines go to the
    // inverse so a design that samples late cannot see a stale copy.
    task automatic xfer(input logic wr, input logic [15:0] a,
                        input logic [15:0] d, output logic [15:0] rd,
                        output logic er, output logic ok);
        @(negedge sys_clk);
        req_valid = 1'b1;
        req_write = wr; // Run command is only ever written 0 or 1.
        req_addr = a;
        req_wdata = d;
        @(posedge sys_clk);
        @(negedge sys_clk);
        ok = resp_valid;
        rd = resp_rdata;
        er = resp_err;
        req_valid = 1'b0;
        req_write = ~wr;
        req_addr = ~a;
        req_wdata = ~d;
    endtask
endmodule

// ==== bench/tb_engine_ctrl_holding_regs.sv ====
// Self-checking bench of the holding-register bank.
module tb_engine_ctrl_holding_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import engine_regs_pkg::*;

    typedef struct packed {
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic err;
    } row_t;

    logic sys_clk = 1'b0;
    logic rst_b;
    logic req_valid;
    logic req_write;
    logic [15:0] req_addr;
    logic [15:0] req_wdata;
    telemetry_t telem;
    logic resp_valid;
    logic [15:0] resp_rdata;
    logic resp_err;
    setpoints_t setp;
    mode_ctrl_t mode_ctrl;
    int miscompares = 0;
    int samples_checked = 0;

    // Plain accesses with their expected answers.
    row_t rows [24] = '{
        '{1'b0, 16'h9c4b, 16'h0000, 16'h01f9, 1'b0},
        '{1'b1, 16'h9c4b, 16'hffff, 16'h0000, 1'b0},
        '{1'b0, 16'h9c4b, 16'h0000, 16'h01f9, 1'b0},
        '{1'b1, 16'h9c4d, 16'h0bb8, 16'h0000, 1'b0},
        '{1'b0, 16'h9c4d, 16'h0000, 16'h0bb8, 1'b0},
        '{1'b1, 16'h9c50, 16'h0708, 16'h0000, 1'b0},
        '{1'b0, 16'h9c50, 16'h0000, 16'h0708, 1'b0},
        '{1'b1, 16'h9c66, 16'h0064, 16'h0000, 1'b0},
        '{1'b0, 16'h9c66, 16'h0000, 16'h0064, 1'b0},
        '{1'b1, 16'h9c67, 16'h00c8, 16'h0000, 1'b0},
        '{1'b0, 16'h9c67, 16'h0000, 16'h00c8, 1'b0},
        '{1'b1, 16'h9c68, 16'h01f9, 16'h0000, 1'b0},
        '{1'b0, 16'h9c68, 16'h0000, 16'h01f9, 1'b0},
        '{1'b1, 16'h9c69, 16'h0032, 16'h0000, 1'b0},
        '{1'b0, 16'h9c69, 16'h0000, 16'h0032, 1'b0},
        '{1'b1, 16'h9c6a, 16'h0019, 16'h0000, 1'b0},
        '{1'b0, 16'h9c6a, 16'h0000, 16'h0019, 1'b0},
        '{1'b0, 16'h9c55, 16'h0000, 16'h0000, 1'b0},
        '{1'b1, 16'h9c80, 16'h1234, 16'h0000, 1'b0},
        '{1'b0, 16'h9c80, 16'h0000, 16'h0000, 1'b0},
        '{1'b0, 16'h9d0b, 16'h0000, 16'h0000, 1'b1},
        '{1'b1, 16'h9d11, 16'h0001, 16'h0000, 1'b1},
        '{1'b0, 16'h9d14, 16'h0000, 16'h0001, 1'b0},
        '{1'b0, 16'h9d15, 16'h0000, 16'h0001, 1'b0}
    };
    // Mode writes: register, value, expected controls a cycle later.
    logic [36:0] mode_rows [7] = '{
        {16'h9c4f, 16'h0001, 5'b10011}, {16'h9c4c, 16'h0001, 5'b10111},
        {16'h9c52, 16'h0001, 5'b10111}, {16'h9c51, 16'h0001, 5'b01001},
        {16'h9c53, 16'h0001, 5'b01000}, {16'h9c51, 16'h0000, 5'b10111},
        {16'h9c4f, 16'h0000, 5'b00000}
    };

    engine_ctrl_holding_regs u_engine_ctrl_holding_regs (
        .sys_clk(sys_clk), .rst_b(rst_b), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .telem(telem), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
        .resp_err(resp_err), .setp(setp), .mode_ctrl(mode_ctrl));

    reg_master_model u_reg_master_model (
        .sys_clk(sys_clk), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata),
        .resp_valid(resp_valid), .resp_rdata(resp_rdata),
        .resp_err(resp_err));

    // Free-running 50 MHz clock.
    always #10 sys_clk = ~sys_clk;

    ////////////////////////////////////////////////////////////////////////
    // Compare one value and count it.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: saw %h expected %h",
                     $time, seen, exp);
        end
    endtask

    // One access with its full answer compared.
    task automatic rw(input logic wr, input logic [15:0] a,
                      input logic [15:0] d, input logic [15:0] er_d,
                      input logic er_e);
        logic [15:0] rd;
        logic er;
        logic ok;
        u_reg_master_model.xfer(wr, a, d, rd, er, ok);
        check({31'h0, ok}, 32'h1);
        check({16'h0, rd}, {16'h0, er_d});
        check({31'h0, er}, {31'h0, er_e});
    endtask

    // Verdict and end of run.
    task automatic summarize();
        if (miscompares == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watchdog: a hang counts as a mismatch.
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        miscompares++;
        summarize();
    end

    // Main sequence.
    initial
    begin
        rst_b = 1'b0;
        telem = '0;
        telem.level = 16'h01f9;
        telem.discharge = 32'h0002_0003;
        telem.inhibit_switch = 1'b1;
        telem.inhibit_active = 1'b1;
        repeat (4) @(negedge sys_clk);
        check(setp[31:0], 32'h0);
        check({27'h0, mode_ctrl}, 32'h0);
        rst_b = 1'b1;
        @(negedge sys_clk);
        check({27'h0, mode_ctrl}, 32'h3);
        foreach (rows[i])
            rw(rows[i].wr, rows[i].addr, rows[i].wdata, rows[i].rdata,
               rows[i].err);
        for (int c = 0; c < 4; c++)
        begin
            telem.regen = regen_state_t'(c);
            rw(1'b0, 16'h9c65, 16'h0, 16'(c), 1'b0);
        end
        rw(1'b1, 16'h9c65, 16'h0000, 16'h0000, 1'b0);
        rw(1'b0, 16'h9c65, 16'h0000, 16'h0003, 1'b0);
        rw(1'b0, 16'h9c6b, 16'h0000, 16'h0002, 1'b0);
        rw(1'b0, 16'h9c6c, 16'h0000, 16'h0003, 1'b0);
        for (int p = 0; p < 3; p++)
        begin
            rw(1'b1, 16'(16'h9c6d + 2 * p), 16'(p + 1), 16'h0, 1'b0);
            rw(1'b1, 16'(16'h9c6e + 2 * p), 16'(16'ha5a0 + p), 16'h0, 1'b0);
            rw(1'b0, 16'(16'h9c6d + 2 * p), 16'h0, 16'(p + 1), 1'b0);
        end
        check(setp.press_start, 32'h0001_a5a0);
        check(setp.press_stop, 32'h0002_a5a1);
        check(setp.press_maintain, 32'h0003_a5a2);
        foreach (mode_rows[m])
        begin
            rw(1'b1, mode_rows[m][36:21], mode_rows[m][20:5], 16'h0, 1'b0);
            @(negedge sys_clk);
            check({27'h0, mode_ctrl},
                  {27'h0, mode_rows[m][4:0]});
        end
        rw(1'b0, 16'h9c53, 16'h0000, 16'h0001, 1'b0);
        // A reset in mid-run must clear settings, not only the controls.
        rst_b = 1'b0;
        @(negedge sys_clk);
        check(setp.press_start, 32'h0);
        check({27'h0, mode_ctrl}, 32'h0);
        rst_b = 1'b1;
        rw(1'b0, 16'h9c4d, 16'h0000, 16'h0000, 1'b0);
        check({27'h0, mode_ctrl}, 32'h3);
        summarize();
    end
endmodule
